/* dv/ssr_chk.sv */
// checker on the serial port pins and register bus
module ssr_chk (
  // clock, reset and bus
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // pin ownership and drives
  input wire logic        scl_oe_o,
  input wire logic        sda_oe_o,
  input wire logic        spi_pins_owned_o,
  input wire logic        i2c_pins_owned_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] c1_ff;
  wire wr = psel_i & penable_i & pwrite_i;
  wire map = paddr_i inside {8'h44, 8'h48, 8'h4C, 8'h50, 8'h54};
  wire en = c1_ff[5];
  wire m8 = en && c1_ff[3:0] == 4'h8;
  wire sl = en && c1_ff[3:1] == 3'h3;
  // shadow of control one; hardware only ever touches bits 7:6
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i) c1_ff <= 8'h00;
    else if (wr && paddr_i == 8'h44) c1_ff <= pwdata_i[7:0];
  sequence s_rs_req;
    wr && paddr_i == 8'h4C && pwdata_i[1] && m8 && !scl_oe_o && !sda_oe_o;
  endsequence
  a_ready_high: assert property (pready_o) else $error("pready low");
  a_err_unmapped: assert property (psel_i && penable_i |-> pslverr_o == !map)
    else $error("pslverr wrong");
  a_restart_scl: assert property (s_rs_req |=> scl_oe_o) else $error("no scl low");
  a_stretch_hold: assert property (sl && !c1_ff[4] ##1 sl && !c1_ff[4] |-> scl_oe_o)
    else $error("no stretch");
  a_stretch_free: assert property (sl && c1_ff[4] ##1 sl && c1_ff[4] |-> !scl_oe_o)
    else $error("scl not freed");
  a_pins_free: assert property (!en ##1 !en |-> !spi_pins_owned_o && !i2c_pins_owned_o)
    else $error("pins not free");
  a_spi_owned: assert property (en && c1_ff[3:0] < 6 ##1 en && c1_ff[3:0] < 6
    |-> spi_pins_owned_o && !i2c_pins_owned_o) else $error("spi pins");
  a_i2c_owned: assert property (en && c1_ff[3:1] inside {3, 4} ##1
    en && c1_ff[3:0] inside {6, 7, 8} |-> i2c_pins_owned_o && !spi_pins_owned_o)
    else $error("i2c pins");
  a_sda_master: assert property (sda_oe_o |-> m8) else $error("sda driven");
endmodule // ssr_chk
bind ssr_serial_port ssr_chk i_chk (.ref_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .scl_oe_o, .sda_oe_o, .spi_pins_owned_o,
  .i2c_pins_owned_o);

/* dv/ssr_i2c_agent.sv */
// open-drain i2c bus with pull-ups and a far device that stretches or holds sda
module ssr_i2c_agent (
  input  wire logic       clk_i,
  input  wire logic       scl_oe_i,
  input  wire logic       sda_oe_i,
  input  wire logic       sda_hold_i,
  input  wire logic [3:0] stretch_i,
  output wire logic       scl_o,
  output wire logic       sda_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_ff = 4'h0;
  // a slow far side keeps scl low a while after the port lets go
  always @(posedge clk_i)
    cnt_ff <= scl_oe_i ? stretch_i : cnt_ff - {3'h0, cnt_ff != 4'h0};
  assign scl_o = !(scl_oe_i || cnt_ff != 4'h0);
  assign sda_o = !(sda_oe_i || sda_hold_i);
endmodule // ssr_i2c_agent

/* dv/tb_sync_serial_port_restart.sv */
// bench: registers, spi loopback, i2c stretch, restart and collision
module tb_sync_serial_port_restart;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic pready_o, pslverr_o, err, scl_i, sda_i, sdo_o, sck_o, hold = 1'b0;
  logic scl_oe_o, sda_oe_o, spi_pins_owned_o, i2c_pins_owned_o;
  logic sck_i = 1'b0, ss_pin_owned_o;
  int error_cnt = 0, checked = 0, cyc = 0, t;
  always #20 ref_clk_i = ~ref_clk_i;
  // sdi loops back from sdo so a master byte comes back unchanged
  ssr_serial_port i_dut (.ref_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .timer_two_tick_i(1'b0), .sck_i,
    .sck_o, .sck_oe_o(), .sdo_o, .sdo_oe_o(), .sdi_i(sdo_o), .ss_n_i(1'b1),
    .spi_pins_owned_o, .ss_pin_owned_o, .scl_i, .scl_o(), .scl_oe_o, .sda_i, .sda_o(),
    .sda_oe_o, .i2c_pins_owned_o);
  ssr_i2c_agent i_bus (.clk_i(ref_clk_i), .scl_oe_i(scl_oe_o), .sda_oe_i(sda_oe_o),
    .sda_hold_i(hold), .stretch_i(4'h3), .scl_o(scl_i), .sda_o(sda_i));
  task automatic final_report;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard well above the longest run
  always @(posedge ref_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      final_report;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  // one apb transfer: setup, then access held until pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rdm(input logic [7:0] a, m, e, input string n);
    xfer(1'b0, a, 8'h00);
    chk(n, {24'h0, e}, rd & {24'h0, m});
  endtask
  // stale read data must not end the wait before the first poll
  task automatic poll(input logic [7:0] a, input int b);
    rd = 32'h0;
    for (int i = 0; i < 300 && rd[b] !== 1'b1; i++) xfer(1'b0, a, 8'h00);
  endtask
  // far spi master: each sck toggle held two cycles so every edge is seen
  task automatic spis(input int n);
    repeat (n)
    begin
      @(posedge ref_clk_i);
      sck_i <= ~sck_i;
      @(posedge ref_clk_i);
    end
  endtask
  initial
  begin
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rdm(8'h44, 8'hFF, 8'h00, "ctl1 reset");
    xfer(1'b1, 8'h44, 8'hFF);
    rdm(8'h44, 8'hFF, 8'hFF, "ctl1 rw");
    xfer(1'b0, 8'h40, 8'h00);
    chk("unmapped err", 1, err);
    chk("unmapped rd", 0, rd);
    for (int m = 0; m < 3; m++)
    begin
      xfer(1'b1, 8'h44, 8'h30 | 8'(m));
      xfer(1'b1, 8'h50, 8'h60);
      chk("sck idle", 1, sck_o);
      chk("spi own", 1, spi_pins_owned_o);
      xfer(1'b1, 8'h48, 8'hA5 ^ 8'(m));
      poll(8'h50, 6);
      rdm(8'h44, 8'h40, 8'h00, "ovf");
      if (m != 1) rdm(8'h48, 8'hFF, 8'hA5 ^ 8'(m), "loopback");
    end
    xfer(1'b1, 8'h44, 8'h26);
    @(posedge ref_clk_i);
    chk("stretch", 2'h3, {scl_oe_o, i2c_pins_owned_o});
    xfer(1'b1, 8'h44, 8'h36);
    @(posedge ref_clk_i);
    chk("release", 0, scl_oe_o);
    xfer(1'b1, 8'h44, 8'h06);
    @(posedge ref_clk_i);
    chk("pins free", 0, i2c_pins_owned_o);
    xfer(1'b1, 8'h54, 8'h03);
    xfer(1'b1, 8'h44, 8'h28);
    xfer(1'b1, 8'h4C, 8'h02);
    hold <= 1'b1;
    poll(8'h50, 5);
    chk("collision", 1, rd[5]);
    rdm(8'h4C, 8'h02, 8'h00, "col rs");
    hold <= 1'b0;
    xfer(1'b1, 8'h50, 8'h60);
    xfer(1'b1, 8'h4C, 8'h02);
    t = cyc;
    @(posedge ref_clk_i);
    chk("scl low", 1, scl_oe_o);
    xfer(1'b1, 8'h48, 8'h3C);
    rdm(8'h44, 8'h80, 8'h80, "write coll");
    xfer(1'b1, 8'h4C, 8'h1D);
    rdm(8'h4C, 8'h1F, 8'h02, "ctl2 lock");
    rdm(8'h48, 8'hFF, 8'hA7, "buf kept");
    poll(8'h50, 6);
    chk("irq delay", 1, cyc - t >= 24);
    chk("start", 1, rd[3]);
    chk("sda held", 1, sda_oe_o);
    rdm(8'h4C, 8'h02, 8'h00, "rs clear");
    xfer(1'b1, 8'h50, 8'h40);
    xfer(1'b1, 8'h48, 8'hA0);
    poll(8'h50, 6);
    chk("ack", 0, rd[1]);
    xfer(1'b1, 8'h44, 8'h25);
    @(posedge ref_clk_i);
    chk("ss free", 0, ss_pin_owned_o);
    xfer(1'b1, 8'h48, 8'h5A);
    spis(16);
    xfer(1'b1, 8'h48, 8'hC3);
    spis(16);
    rdm(8'h44, 8'h40, 8'h40, "slave ovf");
    rdm(8'h48, 8'hFF, 8'h5A, "ovf kept");
    spis(3);
    xfer(1'b1, 8'h48, 8'hFF);
    rdm(8'h44, 8'h80, 8'h80, "slave coll");
    xfer(1'b1, 8'h44, 8'h24);
    @(posedge ref_clk_i);
    chk("ss pin", 1, ss_pin_owned_o);
    final_report;
  end
endmodule // tb_sync_serial_port_restart

/* rtl/ssr_map.vh */
// register map, field positions, reset values and timing counts of the serial port
`ifndef SSR_MAP_VH
`define SSR_MAP_VH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define SSR_IDX_CTL1   6'h11
`define SSR_IDX_BUF    6'h12
`define SSR_IDX_CTL2   6'h13
`define SSR_IDX_STAT   6'h14
`define SSR_IDX_RELOAD 6'h15

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define SSR_C1_WRCOL   7
`define SSR_C1_OV      6
`define SSR_C1_EN      5
`define SSR_C1_POL     4
`define SSR_C2_RESTART 1
`define SSR_ST_FULL    0
`define SSR_ST_ACK     1
`define SSR_ST_START   3
`define SSR_ST_STOP    4
`define SSR_ST_COL     5
`define SSR_ST_IRQ     6
`define SSR_ST_BUSY    7

// ------------------------------------------------------------
// reset values and mode codes
// ------------------------------------------------------------
`define SSR_CTL1_RST   8'h00
`define SSR_CTL2_RST   8'h00
`define SSR_RELOAD_RST 8'h00
`define SSR_MODE_SPIM_TMR 4'h3
`define SSR_MODE_SPIS_SS  4'h4
`define SSR_MODE_SPIS     4'h5
`define SSR_MODE_I2CM     4'h8

// ------------------------------------------------------------
// timing counts in ref_clk cycles (half periods of SPI clock)
// ------------------------------------------------------------
`define SSR_SPI_HALF_DIV4  8'h02
`define SSR_SPI_HALF_DIV16 8'h08
`define SSR_SPI_HALF_DIV64 8'h20

`endif

/* rtl/ssr_serial_port.v */
// synchronous serial port: SPI master/slave, I2C slave, I2C master with repeated start
//
// The implementer's own choice: register access over APB.
`include "ssr_map.vh"

module ssr_serial_port
(
  // clock and reset
  input  wire        ref_clk_i,
  input  wire        rst_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  // timer two output pulse
  input  wire        timer_two_tick_i,
  // spi pins
  input  wire        sck_i,
  output wire        sck_o,
  output wire        sck_oe_o,
  output wire        sdo_o,
  output wire        sdo_oe_o,
  input  wire        sdi_i,
  input  wire        ss_n_i,
  output wire        spi_pins_owned_o,
  output wire        ss_pin_owned_o,
  // i2c pins (open drain)
  input  wire        scl_i,
  output wire        scl_o,
  output wire        scl_oe_o,
  input  wire        sda_i,
  output wire        sda_o,
  output wire        sda_oe_o,
  output wire        i2c_pins_owned_o
);

  // ------------------------------------------------------------
  // states of the master engine
  // ------------------------------------------------------------
  localparam [3:0] ST_IDLE    = 4'd0;
  localparam [3:0] ST_RS_SCLL = 4'd1;
  localparam [3:0] ST_RS_SDAH = 4'd2;
  localparam [3:0] ST_RS_SCLR = 4'd3;
  localparam [3:0] ST_RS_BOTH = 4'd4;
  localparam [3:0] ST_RS_SDAL = 4'd5;
  localparam [3:0] ST_TX_LO   = 4'd6;
  localparam [3:0] ST_TX_HI   = 4'd7;
  localparam [3:0] ST_SPI     = 4'd8;

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  // address match against a register index
  function sel_reg;
    input [7:0] addr;
    input [5:0] idx;
    begin
      sel_reg = (addr == {idx, 2'b00});
    end
  endfunction

  // rate period: 2*(reload[6:0]+1) cycles, counting down to zero
  function [7:0] rate_load;
    input [7:0] reload;
    begin
      rate_load = {reload[6:0], 1'b1};
    end
  endfunction

  // ------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------
  reg [7:0]  ctl1_ff,   nxt_ctl1;
  reg [7:0]  ctl2_ff,   nxt_ctl2;
  reg [7:0]  reload_ff, nxt_reload;
  reg [7:0]  buf_ff,    nxt_buf;
  reg        full_ff,   nxt_full;
  reg        start_ff,  nxt_start;
  reg        stop_ff,   nxt_stop;
  reg        col_ff,    nxt_col;
  reg        irq_ff,    nxt_irq;
  reg        ack_ff,    nxt_ack;
  reg [3:0]  state_ff,  nxt_state;
  reg [7:0]  cnt_ff,    nxt_cnt;
  reg [7:0]  sh_ff,     nxt_sh;
  reg [3:0]  bit_ff,    nxt_bit;
  reg        rxbit_ff,  nxt_rxbit;
  reg        sck_ff,    nxt_sck;
  reg        scl_low_ff, nxt_scl_low;
  reg        sda_low_ff, nxt_sda_low;
  reg        sck_prev_ff;
  reg        scl_prev_ff;
  reg        sda_prev_ff;
  reg [31:0] prdata_ff;
  reg        rx_done;
  reg [7:0]  rx_byte;
  reg        rs_abort;
  reg        spi_step;
  reg [7:0]  spi_load;
  reg [31:0] rd_mux;

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  wire [3:0] mode     = ctl1_ff[3:0];
  wire       en       = ctl1_ff[`SSR_C1_EN];
  wire       idle_pol = ctl1_ff[`SSR_C1_POL];
  wire       m_spim   = en & (mode[3:2] == 2'b00);
  wire       m_spis   = en & (mode[3:1] == 3'b010);
  wire       m_i2cs   = en & (mode[3:1] == 3'b011);
  wire       m_i2cm   = en & (mode == `SSR_MODE_I2CM);
  wire       spi_sel  = (mode == `SSR_MODE_SPIS) | ~ss_n_i;
  wire       rs_busy  = ctl2_ff[`SSR_C2_RESTART];
  wire       i2c_own  = m_i2cs | m_i2cm;

  // bus-level start and stop seen on the i2c lines
  wire       start_det = i2c_own & scl_i & scl_prev_ff & sda_prev_ff & ~sda_i;
  wire       stop_det  = i2c_own & scl_i & scl_prev_ff & ~sda_prev_ff & sda_i;

  // ------------------------------------------------------------
  // apb decode; zero wait states, so every access ends in one cycle
  // ------------------------------------------------------------
  wire acc    = psel_i & penable_i;
  wire wr     = acc & pwrite_i;
  wire rd     = acc & ~pwrite_i;
  wire mapped = sel_reg(paddr_i, `SSR_IDX_CTL1) | sel_reg(paddr_i, `SSR_IDX_BUF) |
                sel_reg(paddr_i, `SSR_IDX_CTL2) | sel_reg(paddr_i, `SSR_IDX_STAT) |
                sel_reg(paddr_i, `SSR_IDX_RELOAD);
  wire [7:0] stat = {(state_ff != ST_IDLE), irq_ff, col_ff, stop_ff, start_ff,
                     1'b0, ack_ff, full_ff};

  assign pready_o  = 1'b1;
  assign pslverr_o = acc & ~mapped;
  assign prdata_o  = prdata_ff;

  // read mux; unmapped reads return zero
  always @*
  begin
    rd_mux = 32'h0000_0000;
    if (sel_reg(paddr_i, `SSR_IDX_CTL1))   rd_mux[7:0] = ctl1_ff;
    if (sel_reg(paddr_i, `SSR_IDX_BUF))    rd_mux[7:0] = buf_ff;
    if (sel_reg(paddr_i, `SSR_IDX_CTL2))   rd_mux[7:0] = ctl2_ff;
    if (sel_reg(paddr_i, `SSR_IDX_STAT))   rd_mux[7:0] = stat;
    if (sel_reg(paddr_i, `SSR_IDX_RELOAD)) rd_mux[7:0] = reload_ff;
  end

  // spi master half-period selection
  always @*
  begin
    case (mode[1:0])
      2'b00:   spi_load = `SSR_SPI_HALF_DIV4 - 8'h01;
      2'b01:   spi_load = `SSR_SPI_HALF_DIV16 - 8'h01;
      default: spi_load = `SSR_SPI_HALF_DIV64 - 8'h01;
    endcase
  end

  // ------------------------------------------------------------
  // next-state logic: software first, then engines; hardware sets win
  // ------------------------------------------------------------
  always @*
  begin
    nxt_ctl1    = ctl1_ff;
    nxt_ctl2    = ctl2_ff;
    nxt_reload  = reload_ff;
    nxt_buf     = buf_ff;
    nxt_full    = full_ff;
    nxt_start   = start_ff;
    nxt_stop    = stop_ff;
    nxt_col     = col_ff;
    nxt_irq     = irq_ff;
    nxt_ack     = ack_ff;
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff;
    nxt_sh      = sh_ff;
    nxt_bit     = bit_ff;
    nxt_rxbit   = rxbit_ff;
    nxt_sck     = sck_ff;
    nxt_scl_low = scl_low_ff;
    nxt_sda_low = sda_low_ff;
    rx_done     = 1'b0;
    rx_byte     = 8'h00;
    rs_abort    = 1'b0;
    spi_step    = 1'b0;

    // software writes
    if (wr & sel_reg(paddr_i, `SSR_IDX_CTL1))
      nxt_ctl1 = pwdata_i[7:0];
    if (wr & sel_reg(paddr_i, `SSR_IDX_RELOAD))
      nxt_reload = pwdata_i[7:0];
    if (wr & sel_reg(paddr_i, `SSR_IDX_STAT))
    begin
      // write one to clear; a same-cycle hardware set still wins below
      if (pwdata_i[`SSR_ST_COL]) nxt_col = 1'b0;
      if (pwdata_i[`SSR_ST_IRQ]) nxt_irq = 1'b0;
    end
    if (rd & sel_reg(paddr_i, `SSR_IDX_BUF))
      nxt_full = 1'b0;
    if (wr & sel_reg(paddr_i, `SSR_IDX_CTL2))
    begin
      nxt_ctl2[7:5] = pwdata_i[7:5];
      if (!rs_busy)
      begin
        nxt_ctl2[4:2] = pwdata_i[4:2];
        nxt_ctl2[0]   = pwdata_i[0];
        // restart only from a quiet master; otherwise the request is dropped
        if (pwdata_i[`SSR_C2_RESTART] & m_i2cm & (state_ff == ST_IDLE))
        begin
          nxt_ctl2[`SSR_C2_RESTART] = 1'b1;
          nxt_state   = ST_RS_SCLL;
          nxt_scl_low = 1'b1;
        end
      end
    end
    if (wr & sel_reg(paddr_i, `SSR_IDX_BUF))
    begin
      if (m_i2cm)
      begin
        if (state_ff != ST_IDLE)
          nxt_ctl1[`SSR_C1_WRCOL] = 1'b1;
        else
        begin
          nxt_sh      = pwdata_i[7:0];
          nxt_bit     = 4'd0;
          nxt_state   = ST_TX_LO;
          nxt_cnt     = rate_load(reload_ff);
          nxt_scl_low = 1'b1;
        end
      end
      else if (m_spim)
      begin
        if (state_ff != ST_IDLE)
          nxt_ctl1[`SSR_C1_WRCOL] = 1'b1;
        else
        begin
          nxt_sh    = pwdata_i[7:0];
          nxt_bit   = 4'd0;
          nxt_state = ST_SPI;
          nxt_cnt   = spi_load;
        end
      end
      else if (m_spis | m_i2cs)
      begin
        if (bit_ff != 4'd0)
          nxt_ctl1[`SSR_C1_WRCOL] = 1'b1;
        else
          nxt_sh = pwdata_i[7:0];
      end
    end

    // master engine: repeated start, i2c byte transmit, spi master byte
    case (state_ff)
      ST_IDLE:
      begin
        nxt_sck = idle_pol;
      end
      ST_RS_SCLL:
      begin
        if (!scl_i)
        begin
          nxt_cnt     = rate_load(reload_ff);
          nxt_sda_low = 1'b0;
          nxt_state   = ST_RS_SDAH;
        end
      end
      ST_RS_SDAH:
      begin
        if (cnt_ff != 8'h00)
          nxt_cnt = cnt_ff - 8'h01;
        else if (sda_i)
        begin
          nxt_scl_low = 1'b0;
          nxt_state   = ST_RS_SCLR;
        end
        else
          rs_abort = 1'b1;
      end
      ST_RS_SCLR:
      begin
        if (scl_i)
        begin
          if (!sda_i)
            rs_abort = 1'b1;
          else
          begin
            nxt_cnt   = rate_load(reload_ff);
            nxt_state = ST_RS_BOTH;
          end
        end
      end
      ST_RS_BOTH:
      begin
        // scl dropping before our sda pull means another master is active
        if (!scl_i || !sda_i)
          rs_abort = 1'b1;
        else if (cnt_ff != 8'h00)
          nxt_cnt = cnt_ff - 8'h01;
        else
        begin
          nxt_sda_low = 1'b1;
          nxt_cnt     = rate_load(reload_ff);
          nxt_state   = ST_RS_SDAL;
        end
      end
      ST_RS_SDAL:
      begin
        if (cnt_ff != 8'h00)
          nxt_cnt = cnt_ff - 8'h01;
        else
        begin
          // no reload here: sda simply stays held low for the next byte
          nxt_ctl2[`SSR_C2_RESTART] = 1'b0;
          nxt_irq   = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      ST_TX_LO:
      begin
        // change sda only once scl is really low, so no false start or stop
        if (!scl_i)
          nxt_sda_low = ~sh_ff[7];
        if (cnt_ff != 8'h00)
          nxt_cnt = cnt_ff - 8'h01;
        else
        begin
          nxt_scl_low = 1'b0;
          nxt_cnt     = rate_load(reload_ff);
          nxt_state   = ST_TX_HI;
        end
      end
      ST_TX_HI:
      begin
        // the count waits while a slave stretches scl
        if (scl_i)
        begin
          if (cnt_ff != 8'h00)
            nxt_cnt = cnt_ff - 8'h01;
          else
          begin
            nxt_scl_low = 1'b1;
            if (bit_ff == 4'd8)
            begin
              nxt_ack   = ~sda_i;
              nxt_irq   = 1'b1;
              nxt_bit   = 4'd0;
              nxt_state = ST_IDLE;
            end
            else
            begin
              nxt_sh    = {sh_ff[6:0], 1'b1};
              nxt_bit   = bit_ff + 4'd1;
              nxt_cnt   = rate_load(reload_ff);
              nxt_state = ST_TX_LO;
            end
          end
        end
      end
      ST_SPI:
      begin
        if (mode == `SSR_MODE_SPIM_TMR)
          spi_step = timer_two_tick_i;
        else if (cnt_ff != 8'h00)
          nxt_cnt = cnt_ff - 8'h01;
        else
        begin
          spi_step = 1'b1;
          nxt_cnt  = spi_load;
        end
        if (spi_step)
        begin
          nxt_sck = ~sck_ff;
          if (sck_ff == idle_pol)
            nxt_rxbit = sdi_i;
          else
          begin
            nxt_sh  = {sh_ff[6:0], rxbit_ff};
            nxt_bit = bit_ff + 4'd1;
            if (bit_ff == 4'd7)
            begin
              rx_done   = 1'b1;
              rx_byte   = {sh_ff[6:0], rxbit_ff};
              nxt_bit   = 4'd0;
              nxt_state = ST_IDLE;
            end
          end
        end
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase

    // collision during restart: let go of both lines and give up
    if (rs_abort)
    begin
      nxt_col     = 1'b1;
      nxt_ctl2[`SSR_C2_RESTART] = 1'b0;
      nxt_scl_low = 1'b0;
      nxt_sda_low = 1'b0;
      nxt_state   = ST_IDLE;
    end

    // spi slave: shift on sck edges while selected
    if (m_spis)
    begin
      if (!spi_sel)
        nxt_bit = 4'd0;
      else if (sck_i != sck_prev_ff)
      begin
        if (sck_i != idle_pol)
          nxt_rxbit = sdi_i;
        else
        begin
          nxt_sh  = {sh_ff[6:0], rxbit_ff};
          nxt_bit = bit_ff + 4'd1;
          if (bit_ff == 4'd7)
          begin
            rx_done = 1'b1;
            rx_byte = {sh_ff[6:0], rxbit_ff};
            nxt_bit = 4'd0;
          end
        end
      end
    end

    // i2c slave: data sampled on scl rise, framing restarted by start
    if (m_i2cs)
    begin
      if (start_det)
        nxt_bit = 4'd0;
      else if (scl_i & ~scl_prev_ff)
      begin
        nxt_sh  = {sh_ff[6:0], sda_i};
        nxt_bit = bit_ff + 4'd1;
        if (bit_ff == 4'd7)
        begin
          rx_done = 1'b1;
          rx_byte = {sh_ff[6:0], sda_i};
          nxt_bit = 4'd0;
        end
      end
    end

    // received byte: overflow keeps the old buffer and drops the new byte
    if (rx_done)
    begin
      if (full_ff & ~m_spim & ~(rd & sel_reg(paddr_i, `SSR_IDX_BUF)))
        nxt_ctl1[`SSR_C1_OV] = 1'b1;
      else
      begin
        nxt_buf  = rx_byte;
        nxt_full = 1'b1;
        nxt_irq  = 1'b1;
      end
    end

    // bus condition status
    if (start_det)
    begin
      nxt_start = 1'b1;
      nxt_stop  = 1'b0;
    end
    if (stop_det)
    begin
      nxt_stop  = 1'b1;
      nxt_start = 1'b0;
    end

    // disabled port: engines parked, lines released
    if (!nxt_ctl1[`SSR_C1_EN])
    begin
      nxt_state   = ST_IDLE;
      nxt_scl_low = 1'b0;
      nxt_sda_low = 1'b0;
      nxt_bit     = 4'd0;
      nxt_ctl2[`SSR_C2_RESTART] = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // flip-flops
  // ------------------------------------------------------------
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctl1_ff     <= `SSR_CTL1_RST;
      ctl2_ff     <= `SSR_CTL2_RST;
      reload_ff   <= `SSR_RELOAD_RST;
      buf_ff      <= 8'h00;
      full_ff     <= 1'b0;
      start_ff    <= 1'b0;
      stop_ff     <= 1'b0;
      col_ff      <= 1'b0;
      irq_ff      <= 1'b0;
      ack_ff      <= 1'b0;
      state_ff    <= ST_IDLE;
      cnt_ff      <= 8'h00;
      sh_ff       <= 8'h00;
      bit_ff      <= 4'd0;
      rxbit_ff    <= 1'b0;
      sck_ff      <= 1'b0;
      scl_low_ff  <= 1'b0;
      sda_low_ff  <= 1'b0;
      sck_prev_ff <= 1'b0;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
      prdata_ff   <= 32'h0000_0000;
    end
    else
    begin
      ctl1_ff     <= nxt_ctl1;
      ctl2_ff     <= nxt_ctl2;
      reload_ff   <= nxt_reload;
      buf_ff      <= nxt_buf;
      full_ff     <= nxt_full;
      start_ff    <= nxt_start;
      stop_ff     <= nxt_stop;
      col_ff      <= nxt_col;
      irq_ff      <= nxt_irq;
      ack_ff      <= nxt_ack;
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      sh_ff       <= nxt_sh;
      bit_ff      <= nxt_bit;
      rxbit_ff    <= nxt_rxbit;
      sck_ff      <= nxt_sck;
      scl_low_ff  <= nxt_scl_low;
      sda_low_ff  <= nxt_sda_low;
      sck_prev_ff <= sck_i;
      scl_prev_ff <= scl_i;
      sda_prev_ff <= sda_i;
      // read data captured in the setup cycle, stable through access
      if (psel_i & ~penable_i)
        prdata_ff <= rd_mux;
    end
  end

  // ------------------------------------------------------------
  // pin drive
  // ------------------------------------------------------------
  assign spi_pins_owned_o = m_spim | m_spis;
  assign ss_pin_owned_o   = en & (mode == `SSR_MODE_SPIS_SS);
  assign i2c_pins_owned_o = i2c_own;
  assign sck_o    = sck_ff;
  assign sck_oe_o = m_spim;
  assign sdo_o    = sh_ff[7];
  assign sdo_oe_o = m_spim | (m_spis & spi_sel);
  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  // slave stretch only follows the polarity bit; the master ignores it
  assign scl_oe_o = (m_i2cm & scl_low_ff) | (m_i2cs & ~idle_pol);
  assign sda_oe_o = m_i2cm & sda_low_ff;

endmodule // ssr_serial_port
